// *** rdc_pkg.sv ***
// Purpose: constants and types for the read inversion centering stage
// Assumes: 100 MHz system clock, four nibbles, 9-bit capture delays
// Notes: register offsets are byte addresses on AHB-Lite
`default_nettype none
package rdc_pkg;
	localparam int CLK_NS = 10;
	localparam int TIMEOUT_NS = 10000;
	localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
	localparam int NIB_N = 4;
	localparam logic [3:0] BEATS = 4'h8;
	localparam logic [8:0] DLY_MAX = 9'h1FF;
	localparam logic [8:0] TAP_0 = 9'h000;
	localparam logic [8:0] TAP_90 = 9'h040;
	localparam logic [8:0] TAP_180 = 9'h080;
	localparam logic [8:0] TAP_270 = 9'h0C0;
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_NO_DATA = 4'h1;
	localparam logic [3:0] ERR_TIMEOUT = 4'hF;
	localparam logic [9:0] PAT_COL = 10'h000;
	localparam logic [1:0] PAT_BG = 2'h0;
	localparam logic [7:0] PAT_EVEN = 8'h00;
	localparam logic [7:0] PAT_ODD = 8'hFF;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0C;
	localparam logic [3:0] PAGE_PRIOR = 4'h1;
	localparam logic [3:0] PAGE_RISE = 4'h2;
	localparam logic [3:0] PAGE_FALL = 4'h3;
	localparam logic [3:0] PAGE_CENTER = 4'h4;
	localparam logic [3:0] PAGE_DUMP0 = 4'h5;
	localparam logic [3:0] PAGE_DUMP1 = 4'h6;
	// Field positions and reset values
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MASK_LSB = 4;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;
	localparam int HI_LSB = 16;
	localparam logic [3:0] DBI_MASK_RST = 4'hF;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {
		CMD_MRS = 2'b00,
		CMD_WR = 2'b01,
		CMD_RD = 2'b10
	} rdc_kind_type;
	typedef enum logic [1:0] {
		PH_LEFT = 2'b00,
		PH_RIGHT = 2'b01,
		PH_DUMP = 2'b10
	} rdc_phase_type;
	typedef struct packed {
		logic valid;
		rdc_kind_type kind;
		logic [9:0] col;
		logic [1:0] bg;
		logic dbi_on;
		logic ext;
	} rdc_cmd_type;
endpackage : rdc_pkg
`default_nettype wire

// *** rdc_top.sv ***
// Purpose: read capture centering with data bus inversion for DDR4
// Assumes: link strobe far slower than SYS_CLK_I, sampled through 2 flops
// Notes: AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Invert captured byte when DBI pin set
// - Start only after write calibration stages
// - Enable inversion in DRAM and fabric
// - Write 0/F pattern at column 0, group 0
// - Skip nibbles without a DBI pin
// - Search starts from prior DQ center
// - Repeat reads at column 0, group 0
// - Step delays down to find left edge
// - Center is (maxleft+minright)/2 plus maxleft
// - Disable inversion in DRAM and fabric
// - No valid data gives code 1, nibble
// - Store edges and centers per nibble
// - On failure save bursts at four taps
module rdc_top
	import rdc_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic PREV_DONE_I,
	input wire logic LINK_CLK_I,
	input wire logic [7:0] LINK_DQ_I,
	input wire logic LINK_DBI_I,
	output var rdc_cmd_type CMD_O,
	output logic INV_EN_O,
	output logic [8:0] RISE_DLY_O,
	output logic [8:0] FALL_DLY_O,
	output logic [1:0] NIBBLE_O,
	output logic IRQ_O
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_MRS_ON = 4'b0001,
		S_WRITE = 4'b0010,
		S_NIB = 4'b0011,
		S_RD = 4'b0100,
		S_WAIT = 4'b0101,
		S_AGG = 4'b0110,
		S_OFF = 4'b0111,
		S_FIN = 4'b1000
	} rdc_state_type;

	rdc_state_type state_r;
	rdc_phase_type phase_r;
	rdc_cmd_type cmd_r;
	logic [1:0] nib_r, dump_idx_r, status_r, irq_mask_r;
	logic [8:0] dly_r, start_r, left_r, agg_l, agg_r;
	logic [9:0] agg_sum;
	logic [9:0] to_cnt_r;
	logic [3:0] beat_r, dbi_mask_r, err_code_r;
	logic [1:0] err_nib_r;
	logic mism_r, busy_r, pass_r, inv_en_r, irq_r, start_req;
	logic [63:0] burst_r;
	logic [7:0] byte_now, last_byte_r;
	logic [31:0] prior_r [NIB_N];
	logic [8:0] rl_r [NIB_N], rr_r [NIB_N], fl_r [NIB_N], fr_r [NIB_N];
	logic [8:0] rc_r [NIB_N], fc_r [NIB_N];
	logic [63:0] dump_r [NIB_N];
	logic [9:0] lsync_1, lsync_2;
	logic lclk_d_r, beat_ev, burst_end, timeout, fail_ev;
	logic ap_wr_r, rd_clr;
	logic [7:0] ap_addr_r;
	logic [31:0] rd_word;

	function automatic logic [8:0] dump_tap(input logic [1:0] k);
		case (k)
			2'h0: dump_tap = TAP_0;
			2'h1: dump_tap = TAP_90;
			2'h2: dump_tap = TAP_180;
			default: dump_tap = TAP_270;
		endcase
	endfunction : dump_tap

	function automatic logic [8:0] dq_mid(input logic [31:0] p);
		dq_mid = 9'((10'(p[8:0]) + 10'(p[HI_LSB+:9])) >> 1);
	endfunction : dq_mid

	// ------------------------------------------------------------
	// Link sampling
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			lsync_1 <= '0;
			lsync_2 <= '0;
			lclk_d_r <= 1'b0;
		end
		else
		begin
			lsync_1 <= {LINK_CLK_I, LINK_DBI_I, LINK_DQ_I};
			lsync_2 <= lsync_1;
			lclk_d_r <= lsync_2[9];
		end
	end

	assign beat_ev = lsync_2[9] && !lclk_d_r && state_r == S_WAIT;
	assign byte_now = lsync_2[7:0] ^ {8{inv_en_r & lsync_2[8]}};
	assign burst_end = state_r == S_WAIT && beat_r == BEATS;
	assign timeout = state_r == S_WAIT && to_cnt_r == 10'(TIMEOUT_CYC);
	assign fail_ev = state_r == S_FIN && err_code_r != ERR_NONE;

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	always_comb
	begin
		rd_word = '0;
		case (HADDR_I[7:4])
			4'h0:
			begin
				case (HADDR_I[7:0])
					OFS_CTRL: rd_word[CTRL_MASK_LSB+:4] = dbi_mask_r;
					OFS_STATUS: rd_word[1:0] = status_r;
					OFS_MASK: rd_word[1:0] = irq_mask_r;
					OFS_RESULT: rd_word = {22'h0, err_nib_r, err_code_r, 2'h0, pass_r, busy_r};
					default: rd_word = '0;
				endcase
			end
			PAGE_PRIOR: rd_word = prior_r[HADDR_I[3:2]];
			PAGE_RISE: rd_word = {7'h0, rr_r[HADDR_I[3:2]], 7'h0, rl_r[HADDR_I[3:2]]};
			PAGE_FALL: rd_word = {7'h0, fr_r[HADDR_I[3:2]], 7'h0, fl_r[HADDR_I[3:2]]};
			PAGE_CENTER: rd_word = {7'h0, fc_r[HADDR_I[3:2]], 7'h0, rc_r[HADDR_I[3:2]]};
			PAGE_DUMP0: rd_word = dump_r[{1'b0, HADDR_I[3]}][HADDR_I[2]*32+:32];
			PAGE_DUMP1: rd_word = dump_r[{1'b1, HADDR_I[3]}][HADDR_I[2]*32+:32];
			default: rd_word = '0;
		endcase
	end

	assign rd_clr = HSEL_I && HREADY_I && HTRANS_I == HTRANS_NONSEQ && !HWRITE_I
		&& HADDR_I[7:0] == OFS_STATUS;
	assign start_req = ap_wr_r && ap_addr_r == OFS_CTRL && HWDATA_I[CTRL_START_BIT];

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			ap_wr_r <= 1'b0;
			ap_addr_r <= '0;
			HRDATA_O <= '0;
			HREADYOUT_O <= 1'b0;
			HRESP_O <= 1'b0;
		end
		else
		begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
			ap_wr_r <= HSEL_I && HREADY_I && HTRANS_I == HTRANS_NONSEQ && HWRITE_I;
			if (HSEL_I && HREADY_I)
			begin
				ap_addr_r <= HADDR_I[7:0];
				HRDATA_O <= rd_word;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			dbi_mask_r <= DBI_MASK_RST;
			irq_mask_r <= IRQ_MASK_RST;
			for (int i = 0; i < NIB_N; i++)
				prior_r[i] <= '0;
		end
		else if (ap_wr_r)
		begin
			if (ap_addr_r == OFS_CTRL)
				dbi_mask_r <= HWDATA_I[CTRL_MASK_LSB+:4];
			if (ap_addr_r == OFS_MASK)
				irq_mask_r <= HWDATA_I[1:0];
			if (ap_addr_r[7:4] == PAGE_PRIOR)
				prior_r[ap_addr_r[3:2]] <= HWDATA_I & 32'h01FF01FF;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			status_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			// Set beats the read clear in the same cycle
			status_r[IRQ_DONE_BIT] <= (status_r[IRQ_DONE_BIT] && !rd_clr) || state_r == S_FIN;
			status_r[IRQ_FAIL_BIT] <= (status_r[IRQ_FAIL_BIT] && !rd_clr) || fail_ev;
			irq_r <= |(status_r & irq_mask_r);
		end
	end
	assign IRQ_O = irq_r;

	// ------------------------------------------------------------
	// Burst capture and compare
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			beat_r <= '0;
			mism_r <= 1'b0;
			to_cnt_r <= '0;
			burst_r <= '0;
			last_byte_r <= '0;
		end
		else if (state_r == S_RD)
		begin
			beat_r <= '0;
			mism_r <= 1'b0;
			to_cnt_r <= '0;
		end
		else if (beat_ev && beat_r != BEATS)
		begin
			beat_r <= beat_r + 4'h1;
			last_byte_r <= byte_now;
			burst_r <= {byte_now, burst_r[63:8]};
			if (byte_now != (beat_r[0] ? PAT_ODD : PAT_EVEN))
				mism_r <= 1'b1;
		end
		else if (state_r == S_WAIT)
			to_cnt_r <= to_cnt_r + 10'h1;
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// aggregate window
	assign agg_l = (prior_r[nib_r][8:0] > left_r) ? prior_r[nib_r][8:0] : left_r;
	assign agg_r = (prior_r[nib_r][HI_LSB+:9] < dly_r) ? prior_r[nib_r][HI_LSB+:9] : dly_r;
	assign agg_sum = ((10'(agg_l) + 10'(agg_r)) >> 1) + 10'(agg_l);

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state_r <= S_IDLE;
			phase_r <= PH_LEFT;
			cmd_r <= '0;
			nib_r <= '0;
			dump_idx_r <= '0;
			dly_r <= '0;
			start_r <= '0;
			left_r <= '0;
			err_code_r <= ERR_NONE;
			err_nib_r <= '0;
			busy_r <= 1'b0;
			pass_r <= 1'b0;
			inv_en_r <= 1'b0;
		end
		else
		begin
			cmd_r <= '0;
			case (state_r)
				S_IDLE:
				begin
					if (start_req && PREV_DONE_I)
					begin
						busy_r <= 1'b1;
						pass_r <= 1'b0;
						err_code_r <= ERR_NONE;
						err_nib_r <= '0;
						state_r <= S_MRS_ON;
					end
				end
				S_MRS_ON:
				begin
					cmd_r <= '{valid: 1'b1, kind: CMD_MRS, col: PAT_COL, bg: PAT_BG,
						dbi_on: 1'b1, ext: 1'b0};
					inv_en_r <= 1'b1;
					state_r <= S_WRITE;
				end
				S_WRITE:
				begin
					cmd_r <= '{valid: 1'b1, kind: CMD_WR, col: PAT_COL, bg: PAT_BG,
						dbi_on: 1'b1, ext: 1'b1};
					nib_r <= '0;
					state_r <= S_NIB;
				end
				S_NIB:
				begin
					if (!dbi_mask_r[nib_r])
					begin
						if (nib_r == 2'(NIB_N - 1))
							state_r <= S_OFF;
						else
							nib_r <= nib_r + 2'h1;
					end
					else
					begin
						dly_r <= dq_mid(prior_r[nib_r]);
						start_r <= dq_mid(prior_r[nib_r]);
						phase_r <= PH_LEFT;
						state_r <= S_RD;
					end
				end
				S_RD:
				begin
					cmd_r <= '{valid: 1'b1, kind: CMD_RD, col: PAT_COL, bg: PAT_BG,
						dbi_on: 1'b1, ext: 1'b0};
					state_r <= S_WAIT;
				end
				S_WAIT:
				begin
					if (phase_r == PH_DUMP && (burst_end || timeout))
					begin
						if (dump_idx_r == 2'h3)
							state_r <= S_OFF;
						else
						begin
							dump_idx_r <= dump_idx_r + 2'h1;
							dly_r <= dump_tap(dump_idx_r + 2'h1);
							state_r <= S_RD;
						end
					end
					else if (timeout)
					begin
						err_code_r <= ERR_TIMEOUT;
						err_nib_r <= nib_r;
						phase_r <= PH_DUMP;
						dump_idx_r <= '0;
						dly_r <= TAP_0;
						state_r <= S_RD;
					end
					else if (burst_end && phase_r == PH_LEFT)
					begin
						if (mism_r && dly_r == start_r)
						begin
							err_code_r <= ERR_NO_DATA;
							err_nib_r <= nib_r;
							phase_r <= PH_DUMP;
							dump_idx_r <= '0;
							dly_r <= TAP_0;
						end
						else if (!mism_r && dly_r != 9'h000)
							dly_r <= dly_r - 9'h001;
						else
						begin
							left_r <= mism_r ? dly_r + 9'h001 : dly_r;
							dly_r <= start_r;
							phase_r <= PH_RIGHT;
						end
						state_r <= S_RD;
					end
					else if (burst_end)
					begin
						if (!mism_r && dly_r != DLY_MAX)
						begin
							dly_r <= dly_r + 9'h001;
							state_r <= S_RD;
						end
						else
						begin
							if (mism_r)
								dly_r <= dly_r - 9'h001;
							state_r <= S_AGG;
						end
					end
				end
				S_AGG:
				begin
					if (nib_r == 2'(NIB_N - 1))
						state_r <= S_OFF;
					else
					begin
						nib_r <= nib_r + 2'h1;
						state_r <= S_NIB;
					end
				end
				S_OFF:
				begin
					cmd_r <= '{valid: 1'b1, kind: CMD_MRS, col: PAT_COL, bg: PAT_BG,
						dbi_on: 1'b0, ext: 1'b0};
					inv_en_r <= 1'b0;
					state_r <= S_FIN;
				end
				S_FIN:
				begin
					busy_r <= 1'b0;
					pass_r <= err_code_r == ERR_NONE;
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Per-nibble results
	// ------------------------------------------------------------
	for (genvar g = 0; g < NIB_N; g++)
	begin : g_res
		always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
		begin
			if (!RESETN_I)
			begin
				rl_r[g] <= '0;
				rr_r[g] <= '0;
				fl_r[g] <= '0;
				fr_r[g] <= '0;
				rc_r[g] <= '0;
				fc_r[g] <= '0;
				dump_r[g] <= '0;
			end
			else
			begin
				if (state_r == S_AGG && nib_r == 2'(g))
				begin
					rl_r[g] <= left_r;
					rr_r[g] <= dly_r;
					fl_r[g] <= left_r;
					fr_r[g] <= dly_r;
					rc_r[g] <= agg_sum > 10'(DLY_MAX) ? DLY_MAX : agg_sum[8:0];
					fc_r[g] <= agg_sum > 10'(DLY_MAX) ? DLY_MAX : agg_sum[8:0];
				end
				if (state_r == S_WAIT && phase_r == PH_DUMP && (burst_end || timeout)
					&& dump_idx_r == 2'(g))
					dump_r[g] <= burst_r;
			end
		end
	end

	assign CMD_O = cmd_r;
	assign INV_EN_O = inv_en_r;
	assign RISE_DLY_O = dly_r;
	assign FALL_DLY_O = dly_r;
	assign NIBBLE_O = nib_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);

	inv_byte_a: assert property (beat_ev && beat_r != BEATS && inv_en_r && lsync_2[8]
		|=> last_byte_r == ~$past(lsync_2[7:0])) else $error("inverted byte wrong");
	start_gate_a: assert property (state_r == S_IDLE && !PREV_DONE_I
		|=> state_r == S_IDLE) else $error("started before write stages");
	mrs_on_a: assert property (state_r == S_MRS_ON
		|=> CMD_O.valid && CMD_O.kind == CMD_MRS && CMD_O.dbi_on && INV_EN_O)
		else $error("inversion not enabled");
	cmd_addr_a: assert property (CMD_O.valid
		|-> CMD_O.col == PAT_COL && CMD_O.bg == PAT_BG) else $error("bad address");
	skip_nib_a: assert property (state_r == S_NIB && !dbi_mask_r[nib_r] && nib_r != 2'h3
		|=> state_r == S_NIB && nib_r == $past(nib_r) + 2'h1) else $error("no skip");
	left_step_a: assert property (burst_end && phase_r == PH_LEFT && !mism_r
		&& dly_r != 9'h000 && !timeout |=> RISE_DLY_O == $past(dly_r) - 9'h001)
		else $error("left step wrong");
	mrs_off_a: assert property (state_r == S_OFF
		|=> CMD_O.valid && !CMD_O.dbi_on && !INV_EN_O ##1 !CMD_O.valid)
		else $error("inversion not disabled");
	timeout_a: assert property (timeout && phase_r != PH_DUMP
		|=> err_code_r == ERR_TIMEOUT && err_nib_r == $past(nib_r)) else $error("no timeout code");
	pass_flag_a: assert property ($rose(pass_r) |-> err_code_r == ERR_NONE)
		else $error("pass with error");
endmodule : rdc_top
`default_nettype wire

// *** rdc_dram_model.sv ***
// Purpose: DRAM read return model for the inversion centering stage
// Assumes: one burst at a time, 8 beats, strobe period 160 ns
// Notes: data is good only while the capture delay is in the window
`timescale 1ns/1ps
`default_nettype none
module rdc_dram_model
	import rdc_pkg::*;
#(
	parameter logic [8:0] WIN_LO = 9'h024,
	parameter logic [8:0] WIN_HI = 9'h02C
)
(
	input wire logic clk_i,
	input wire rdc_cmd_type cmd_i,
	input wire logic [8:0] dly_i,
	input wire logic mute_i,
	input wire logic broken_i,
	input wire logic [7:0] lat_i,
	output logic link_clk_o,
	output logic [7:0] dq_o,
	output logic dbi_o,
	output logic dbi_mode_o
);
	// --------
	// Burst return
	// --------
	logic [8:0] rdq[$];

	task automatic send_burst(input logic [8:0] dly);
		logic ok;
		logic [7:0] b;
		ok = dly >= WIN_LO && dly <= WIN_HI && !broken_i;
		repeat (lat_i) @(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			b = ok ? {8{i[0]}} : 8'h5A ^ 8'(i);
			dbi_o = dbi_mode_o && $countones(b) < 4;
			dq_o = dbi_o ? ~b : b;
			#40 link_clk_o = 1'b1;
			#80 link_clk_o = 1'b0;
			#40;
		end
		// Released lines must not keep the last beat
		dq_o = ~dq_o;
		dbi_o = ~dbi_o;
	endtask : send_burst

	// --------
	// Command decode
	// --------
	initial
	begin
		dbi_mode_o = 1'b0;
		forever
		begin
			@(posedge clk_i);
			if (cmd_i.valid === 1'b1 && cmd_i.kind == CMD_MRS)
				dbi_mode_o = cmd_i.dbi_on;
			// Reads queue up: the next one may come while a burst tail is still out
			if (cmd_i.valid === 1'b1 && cmd_i.kind == CMD_RD && !mute_i)
				rdq.push_back(dly_i);
		end
	end

	initial
	begin
		link_clk_o = 1'b0;
		dq_o = 8'h00;
		dbi_o = 1'b0;
		forever
		begin
			@(posedge clk_i);
			if (rdq.size() != 0)
				send_burst(rdq.pop_front());
		end
	end
endmodule : rdc_dram_model
`default_nettype wire

// *** read_dbi_centering_calibration_test.sv ***
// Purpose: register level test of the read inversion centering stage
// Assumes: DRAM window 0x24..0x2C, prior DQ window 0x20..0x30
// Notes: HSIZE is tied to word; HREADY loops back from the slave
`timescale 1ns/1ps
`default_nettype none
module read_dbi_centering_calibration_test
	import rdc_pkg::*;
;
	logic sys_clk, resetn, hsel, hwrite, hready, hresp, prev_done;
	logic link_clk, dbi, inv_en, irq, mute, broken, dbi_mode;
	logic [1:0] htrans, nibble;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] dq, lat;
	logic [8:0] rise_dly, fall_dly;
	logic [8:0] taps[4] = '{TAP_0, TAP_90, TAP_180, TAP_270};
	rdc_cmd_type cmd;
	rdc_cmd_type cq[$];
	logic [8:0] dlyq[$];
	logic [1:0] nibq[$];
	logic invq[$];
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int i;
	int k;

	rdc_top dut
	(
		.SYS_CLK_I(sys_clk),
		.RESETN_I(resetn),
		.HSEL_I(hsel),
		.HADDR_I(haddr),
		.HTRANS_I(htrans),
		.HWRITE_I(hwrite),
		.HSIZE_I(3'h2),
		.HWDATA_I(hwdata),
		.HREADY_I(hready),
		.HRDATA_O(hrdata),
		.HREADYOUT_O(hready),
		.HRESP_O(hresp),
		.PREV_DONE_I(prev_done),
		.LINK_CLK_I(link_clk),
		.LINK_DQ_I(dq),
		.LINK_DBI_I(dbi),
		.CMD_O(cmd),
		.INV_EN_O(inv_en),
		.RISE_DLY_O(rise_dly),
		.FALL_DLY_O(fall_dly),
		.NIBBLE_O(nibble),
		.IRQ_O(irq)
	);

	rdc_dram_model dram
	(
		.clk_i(sys_clk),
		.cmd_i(cmd),
		.dly_i(rise_dly),
		.mute_i(mute),
		.broken_i(broken),
		.lat_i(lat),
		.link_clk_o(link_clk),
		.dq_o(dq),
		.dbi_o(dbi),
		.dbi_mode_o(dbi_mode)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// --------
	// Tasks
	// --------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge sys_clk);
		while (hready !== 1'b1)
			@(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hready !== 1'b1)
			@(posedge sys_clk);
		rd = hrdata;
	endtask : xfer

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		check(rd, exp);
		check(hresp, 1'b0);
	endtask : rdchk

	task automatic wait_idle;
		int n;
		n = 0;
		xfer(OFS_RESULT, 1'b0, 32'h0);
		while ((rd[0] !== 1'b0 || n < 2) && n < 4000)
		begin
			xfer(OFS_RESULT, 1'b0, 32'h0);
			n++;
		end
		if (n >= 4000)
			num_errors++;
	endtask : wait_idle

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cmd.valid === 1'b1)
		begin
			cq.push_back(cmd);
			dlyq.push_back(rise_dly);
			nibq.push_back(nibble);
			invq.push_back(inv_en);
		end
		if (cycles == 40000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	// --------
	// Scenarios
	// --------
	initial
	begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		prev_done = 1'b0;
		mute = 1'b0;
		broken = 1'b0;
		lat = 8'h14;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rdchk(OFS_CTRL, 32'h000000F0);
		rdchk(OFS_MASK, 32'h0);
		xfer(8'hFC, 1'b1, 32'hFFFFFFFF);
		rdchk(8'hFC, 32'h0);
		xfer(8'h10, 1'b1, 32'h00300020);
		xfer(8'h18, 1'b1, 32'h00300020);
		rdchk(8'h10, 32'h00300020);
		xfer(OFS_CTRL, 1'b1, 32'h51);
		repeat (10) @(posedge sys_clk);
		check(cq.size(), 0);
		rdchk(OFS_RESULT, 32'h0);
		prev_done <= 1'b1;
		xfer(OFS_MASK, 1'b1, 32'h3);
		xfer(OFS_CTRL, 1'b1, 32'h51);
		i = 0;
		while (irq !== 1'b1 && i++ < 20000)
			@(posedge sys_clk);
		check(irq, 1'b1);
		check({rise_dly, fall_dly}, {9'h02C, 9'h02C});
		check({cq[0].kind, cq[0].dbi_on, invq[0]}, {CMD_MRS, 2'b11});
		check({cq[1].kind, cq[1].col, cq[1].bg, cq[1].ext}, {CMD_WR, 13'h1});
		check({cq[$].kind, cq[$].dbi_on, inv_en}, {CMD_MRS, 2'b00});
		check(dbi_mode, 1'b0);
		check({dlyq[2], dlyq[3]}, {9'h028, 9'h027});
		k = 0;
		for (i = 2; i < cq.size() - 1; i++)
		begin
			check({cq[i].kind, cq[i].col, cq[i].bg}, {CMD_RD, 12'h0});
			check({nibq[i][0], invq[i]}, 2'b01);
			if (k == 0 && nibq[i] == 2'h2)
			begin
				check(dlyq[i], 9'h028);
				k = 1;
			end
		end
		check(k, 1);
		rdchk(OFS_RESULT, 32'h2);
		for (i = 0; i < 3; i += 2)
		begin
			rdchk(8'h20 + 8'(4 * i), 32'h002C0024);
			rdchk(8'h30 + 8'(4 * i), 32'h002C0024);
			rdchk(8'h40 + 8'(4 * i), 32'h004C004C);
		end
		rdchk(OFS_STATUS, 32'h1);
		rdchk(OFS_STATUS, 32'h0);
		repeat (2) @(posedge sys_clk);
		check(irq, 1'b0);
		lat <= 8'h02;
		mute <= 1'b1;
		xfer(OFS_MASK, 1'b1, 32'h0);
		xfer(OFS_CTRL, 1'b1, 32'h51);
		wait_idle();
		rdchk(OFS_RESULT, 32'h000000F0);
		check(irq, 1'b0);
		xfer(OFS_MASK, 1'b1, 32'h3);
		repeat (2) @(posedge sys_clk);
		check(irq, 1'b1);
		rdchk(OFS_STATUS, 32'h3);
		repeat (2) @(posedge sys_clk);
		check(irq, 1'b0);
		mute <= 1'b0;
		broken <= 1'b1;
		cq.delete();
		dlyq.delete();
		xfer(OFS_CTRL, 1'b1, 32'h41);
		wait_idle();
		rdchk(OFS_RESULT, 32'h00000210);
		for (k = 0; k < 4; k++)
			check(dlyq[dlyq.size() - 5 + k], taps[k]);
		rdchk(8'h50, 32'h59585B5A);
		rdchk(8'h54, 32'h5D5C5F5E);
		print_verdict();
	end
endmodule : read_dbi_centering_calibration_test
`default_nettype wire
